// ==== sfs_pkg.sv ====
/*
 * constants, opcodes, status layout and state type for the serial flash
 * timing sequencer. assumes a 100 MHz core clock and an 8-bit serial link.
 */
package sfs_pkg;

    localparam int unsigned CLK_MHZ         = 100;

    // times in their own units, as printed (maximum figures, except the wake low width, which is a minimum)
    localparam int unsigned LOCK_TIME_US    = 200;
    localparam int unsigned U_ENTRY_TIME_US = 3;
    localparam int unsigned U_EXIT_LO_US    = 240;
    localparam int unsigned U_EXIT_HI_US    = 120;
    localparam int unsigned D_ENTRY_TIME_US = 2;
    localparam int unsigned D_RESUME_US     = 35;
    localparam int unsigned XFR_TIME_US     = 100;
    localparam int unsigned COMP_TIME_US    = 100;
    localparam int unsigned EP_TIME_MS      = 25;
    localparam int unsigned OTP_TIME_US     = 500;
    localparam int unsigned WAKE_LOW_NS     = 20;

    // longest times round down, least times round up
    localparam int unsigned LOCK_CYC_DEF    = LOCK_TIME_US * CLK_MHZ;
    localparam int unsigned U_ENTRY_CYC     = U_ENTRY_TIME_US * CLK_MHZ;
    localparam int unsigned U_EXIT_LO_DEF   = U_EXIT_LO_US * CLK_MHZ;
    localparam int unsigned U_EXIT_HI_DEF   = U_EXIT_HI_US * CLK_MHZ;
    localparam int unsigned D_ENTRY_CYC     = D_ENTRY_TIME_US * CLK_MHZ;
    localparam int unsigned D_RESUME_CYC    = D_RESUME_US * CLK_MHZ;
    localparam int unsigned XFR_CYC_DEF     = XFR_TIME_US * CLK_MHZ;
    localparam int unsigned COMP_CYC_DEF    = COMP_TIME_US * CLK_MHZ;
    localparam int unsigned EP_CYC_DEF      = EP_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned OTP_CYC_DEF     = OTP_TIME_US * CLK_MHZ;
    localparam int unsigned WAKE_LOW_CYC    = (WAKE_LOW_NS * CLK_MHZ + 999) / 1000;

    // cycles lost between cs rise at the pin and ready: up to three to the timer load, one from done to ready
    localparam int unsigned SEQ_LAT_CYC     = 4;

    localparam int unsigned TMR_W           = 22;
    typedef logic [TMR_W-1:0] sfs_cnt_t;

    // opcodes
    localparam logic [7:0] OP_STATUS_READ   = 8'hD7;
    localparam logic [7:0] OP_FREEZE_LOCK   = 8'hC1;
    localparam logic [7:0] OP_ULTRA_SLEEP   = 8'hC2;
    localparam logic [7:0] OP_DEEP_SLEEP    = 8'hC3;
    localparam logic [7:0] OP_DEEP_RESUME   = 8'hC4;
    localparam logic [7:0] OP_PAGE_TO_BUF   = 8'hC5;
    localparam logic [7:0] OP_PAGE_COMPARE  = 8'hC6;
    localparam logic [7:0] OP_ERASE_PROGRAM = 8'hC7;
    localparam logic [7:0] OP_OTP_PROGRAM   = 8'hC8;

    // status byte layout
    localparam int unsigned STAT_READY_BIT  = 7;
    localparam int unsigned STAT_PROT_BIT   = 1;

    // values after reset
    localparam logic [7:0] OPCODE_RST       = 8'h00;
    localparam logic       CS_B_RST         = 1'b1;
    localparam logic       WP_B_RST         = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BUSY,
        ST_U_ENTER,
        ST_U_SLEEP,
        ST_U_WAKE,
        ST_D_ENTER,
        ST_D_SLEEP,
        ST_D_RESUME
    } sfs_state_t;

endpackage

// ==== sfs_sync.sv ====
/*
 * two-flop level synchroniser, any width.
 * assumes each bit is a slow level or a toggle; no bus coherency across bits.
 */
module sfs_sync
#(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;

    // meta feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta <= RST_VAL;
            q_o  <= RST_VAL;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

// ==== sfs_timer.sv ====
/*
 * one-shot down counter: done_o pulses count_i cycles after a load.
 * assumes count_i is at least one; a load while running restarts it.
 */
module sfs_timer
    import sfs_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_b_i,
    input  wire logic     load_i,
    input  wire sfs_cnt_t count_i,
    output logic          done_o,
    output logic          running_o
);

    sfs_cnt_t cnt;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt       <= '0;
            running_o <= 1'b0;
            done_o    <= 1'b0;
        end
        else if (load_i)
        begin
            cnt       <= count_i;
            running_o <= 1'b1;
            done_o    <= 1'b0;
        end
        else if (running_o && cnt <= sfs_cnt_t'(1))
        begin
            running_o <= 1'b0;
            done_o    <= 1'b1;
        end
        else
        begin
            cnt    <= running_o ? cnt - sfs_cnt_t'(1) : cnt;
            done_o <= 1'b0;
        end
    end

endmodule

// ==== sfs_sequencer.sv ====
/*
 * serial flash timing sequencer: serial link slave on the host's clock,
 * command timing, power-down states and write-protect response on ref_clk_i.
 * assumes the host drives sck_i, cs_b_i and mosi_i, keeps its own clock
 * limits and waits out each busy time before the next array command.
 */
// Summary of operation
// - device launches output on falling clock, samples input on rising clock.
// - protection follows write-protect pin within 1 us in both directions.
// - freeze lockdown completes within 200 us after select rises.
// - ultra-deep power-down entered within 3 us after select rises.
// - ready within 240 us after wake pulse, 120 us on high supply.
// - deep power-down entered within 2 us after select rises.
// - operational within 35 us after resume from deep power-down.
// - page to buffer copy finishes within 100 us.
// - page to buffer compare finishes within 100 us.
// - combined page erase and program finishes within 25 ms.
// - one-time-programmable register program finishes within 500 us.
// - output valid while clock still low in the compatible timing.
// - commands accepted with clock idling low or high at select fall.
module sfs_sequencer
    import sfs_pkg::*;
#(
    parameter int unsigned LOCK_CYC    = LOCK_CYC_DEF,
    parameter int unsigned U_EXIT_LO   = U_EXIT_LO_DEF,
    parameter int unsigned U_EXIT_HI   = U_EXIT_HI_DEF,
    parameter int unsigned XFR_CYC     = XFR_CYC_DEF,
    parameter int unsigned COMP_CYC    = COMP_CYC_DEF,
    parameter int unsigned EP_CYC      = EP_CYC_DEF,
    parameter int unsigned OTP_CYC     = OTP_CYC_DEF
)
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       sck_i,
    input  wire logic       cs_b_i,
    input  wire logic       mosi_i,
    input  wire logic       wp_b_i,
    input  wire logic       high_supply_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    output logic            ready_o,
    output logic            protect_o,
    output logic            ultra_sleep_o,
    output logic            deep_sleep_o,
    output logic            op_done_o,
    output logic [7:0]      last_cmd_o
);

    // link side, clocked by sck_i
    logic       link_clr;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic       have_op;
    logic       is_stat;
    logic [7:0] opcode;
    logic       op_tog;
    logic [7:0] rx_byte;
    logic       op_strobe;
    logic [2:0] tx_cnt;
    logic [6:0] tx_sh;
    logic [2:0] core_flags_s;
    logic [7:0] stat_byte;

    // core side, clocked by ref_clk_i
    logic       cs_b_s;
    logic       cs_b_prev;
    logic       cs_rise;
    logic       wp_b_s;
    logic       high_s;
    logic       tog_s;
    logic       tog_seen;
    logic       op_evt;
    logic       pend_q;
    logic       pend;
    logic [7:0] cmd_q;
    logic [7:0] cmd;
    logic [1:0] low_cnt;
    logic       wake_ok;
    sfs_state_t state;
    sfs_state_t next_state;
    logic       tmr_load;
    sfs_cnt_t   tmr_count;
    logic       tmr_done;
    logic       awake;

    // select high ends the frame and clears the link; no edge is counted on
    // after the last one, so the frame's own signal does the cleanup
    assign link_clr  = cs_b_i | ~rst_b_i;
    assign rx_byte   = {rx_sh, mosi_i};
    assign op_strobe = (bit_cnt == 3'h7) && !have_op;

    // only rising edges shift in, so either idle clock level works
    always_ff @(posedge sck_i or posedge link_clr)
    begin
        if (link_clr)
        begin
            bit_cnt <= 3'h0;
            rx_sh   <= 7'h00;
            have_op <= 1'b0;
            is_stat <= 1'b0;
        end
        else
        begin
            rx_sh   <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (op_strobe)
            begin
                have_op <= 1'b1;
                is_stat <= (rx_byte == OP_STATUS_READ);
            end
        end
    end

    // opcode word held past the frame; the toggle flags it to the core
    always_ff @(posedge sck_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            opcode <= OPCODE_RST;
            op_tog <= 1'b0;
        end
        else if (op_strobe)
        begin
            opcode <= rx_byte;
            op_tog <= ~op_tog;
        end
    end

    // core state seen by the link; settles in the eight opcode edges
    sfs_sync #(
        .W       (3),
        .RST_VAL (3'b000)
    ) u_link_sync (
        .clk_i   (sck_i),
        .rst_b_i (rst_b_i),
        .d_i     ({ready_o, protect_o, awake}),
        .q_o     (core_flags_s)
    );

    always_comb
    begin
        stat_byte = 8'h00;
        stat_byte[STAT_READY_BIT] = core_flags_s[2];
        stat_byte[STAT_PROT_BIT]  = core_flags_s[1];
    end

    // launch on falling edge gives the host a full cycle to capture
    always_ff @(negedge sck_i or posedge link_clr)
    begin
        if (link_clr)
        begin
            miso_o    <= 1'b0;
            miso_oe_o <= 1'b0;
            tx_cnt    <= 3'h0;
            tx_sh     <= 7'h00;
        end
        else if (is_stat && core_flags_s[0])
        begin
            miso_oe_o <= 1'b1;
            tx_cnt    <= tx_cnt + 3'h1;
            if (tx_cnt == 3'h0)
            begin
                miso_o <= stat_byte[7];
                tx_sh  <= stat_byte[6:0];
            end
            else
            begin
                miso_o <= tx_sh[6];
                tx_sh  <= {tx_sh[5:0], 1'b0};
            end
        end
    end

    sfs_sync #(
        .W       (4),
        .RST_VAL ({CS_B_RST, WP_B_RST, 1'b0, 1'b0})
    ) u_core_sync (
        .clk_i   (ref_clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({cs_b_i, wp_b_i, high_supply_i, op_tog}),
        .q_o     ({cs_b_s, wp_b_s, high_s, tog_s})
    );

    assign cs_rise = cs_b_s & ~cs_b_prev;
    assign op_evt  = tog_s ^ tog_seen;
    assign wake_ok = (low_cnt >= 2'(WAKE_LOW_CYC));
    assign pend    = pend_q | op_evt;
    assign cmd     = op_evt ? opcode : cmd_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cs_b_prev <= CS_B_RST;
            tog_seen  <= 1'b0;
        end
        else
        begin
            cs_b_prev <= cs_b_s;
            tog_seen  <= tog_s;
        end
    end

    // an opcode landing with the select rise is used at once, never left to replay
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pend_q <= 1'b0;
            cmd_q  <= OPCODE_RST;
        end
        else
        begin
            pend_q <= pend & ~cs_rise;
            cmd_q  <= cmd;
        end
    end

    // select low width, saturating, for the wake pulse
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            low_cnt <= 2'h0;
        end
        else if (cs_b_s)
        begin
            low_cnt <= 2'h0;
        end
        else if (!wake_ok)
        begin
            low_cnt <= low_cnt + 2'h1;
        end
    end

    // sync path is a few cycles, far inside 1 us
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            protect_o <= ~WP_B_RST;
        end
        else
        begin
            protect_o <= ~wp_b_s;
        end
    end

    sfs_timer u_timer (
        .clk_i     (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .done_o    (tmr_done),
        .running_o ()
    );

    // counts trimmed by the pin-to-ready latency so the limit is kept
    always_comb
    begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_count  = sfs_cnt_t'(1);
        unique case (state)
            ST_IDLE:
            begin
                if (pend && cs_rise)
                begin
                    tmr_load = 1'b1;
                    if (cmd == OP_FREEZE_LOCK)
                    begin
                        next_state = ST_BUSY;
                        tmr_count  = sfs_cnt_t'(LOCK_CYC - SEQ_LAT_CYC);
                    end
                    else if (cmd == OP_PAGE_TO_BUF)
                    begin
                        next_state = ST_BUSY;
                        tmr_count  = sfs_cnt_t'(XFR_CYC - SEQ_LAT_CYC);
                    end
                    else if (cmd == OP_PAGE_COMPARE)
                    begin
                        next_state = ST_BUSY;
                        tmr_count  = sfs_cnt_t'(COMP_CYC - SEQ_LAT_CYC);
                    end
                    else if (cmd == OP_ERASE_PROGRAM)
                    begin
                        next_state = ST_BUSY;
                        tmr_count  = sfs_cnt_t'(EP_CYC - SEQ_LAT_CYC);
                    end
                    else if (cmd == OP_OTP_PROGRAM)
                    begin
                        next_state = ST_BUSY;
                        tmr_count  = sfs_cnt_t'(OTP_CYC - SEQ_LAT_CYC);
                    end
                    else if (cmd == OP_ULTRA_SLEEP)
                    begin
                        next_state = ST_U_ENTER;
                        tmr_count  = sfs_cnt_t'(U_ENTRY_CYC - SEQ_LAT_CYC);
                    end
                    else if (cmd == OP_DEEP_SLEEP)
                    begin
                        next_state = ST_D_ENTER;
                        tmr_count  = sfs_cnt_t'(D_ENTRY_CYC - SEQ_LAT_CYC);
                    end
                    else
                    begin
                        tmr_load = 1'b0;
                    end
                end
            end
            ST_BUSY:
            begin
                // commands in flight are dropped, the host must wait
                if (tmr_done)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_U_ENTER:
            begin
                if (tmr_done)
                begin
                    next_state = ST_U_SLEEP;
                end
            end
            ST_U_SLEEP:
            begin
                // any long enough select pulse wakes; its content is ignored
                if (cs_rise && wake_ok)
                begin
                    next_state = ST_U_WAKE;
                    tmr_load   = 1'b1;
                    tmr_count  = high_s ? sfs_cnt_t'(U_EXIT_HI - SEQ_LAT_CYC)
                                        : sfs_cnt_t'(U_EXIT_LO - SEQ_LAT_CYC);
                end
            end
            ST_U_WAKE:
            begin
                if (tmr_done)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_D_ENTER:
            begin
                if (tmr_done)
                begin
                    next_state = ST_D_SLEEP;
                end
            end
            ST_D_SLEEP:
            begin
                if (pend && cs_rise && cmd == OP_DEEP_RESUME)
                begin
                    next_state = ST_D_RESUME;
                    tmr_load   = 1'b1;
                    tmr_count  = sfs_cnt_t'(D_RESUME_CYC - SEQ_LAT_CYC);
                end
            end
            ST_D_RESUME:
            begin
                if (tmr_done)
                begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state         <= ST_IDLE;
            ready_o       <= 1'b1;
            ultra_sleep_o <= 1'b0;
            deep_sleep_o  <= 1'b0;
            awake         <= 1'b1;
            op_done_o     <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            ready_o       <= (next_state == ST_IDLE);
            ultra_sleep_o <= (next_state == ST_U_SLEEP);
            deep_sleep_o  <= (next_state == ST_D_SLEEP);
            awake         <= (next_state == ST_IDLE) || (next_state == ST_BUSY);
            op_done_o     <= (state != ST_IDLE) && (next_state == ST_IDLE);
        end
    end

    // last command taken, for debug visibility; a wake pulse is no command
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            last_cmd_o <= OPCODE_RST;
        end
        else if (tmr_load && state != ST_U_SLEEP)
        begin
            last_cmd_o <= cmd;
        end
    end

endmodule

// ==== sfs_sequencer_props.sv ====
/* sfs_sequencer_props: assertions on the sequencer's top ports.
   assumes one ref_clk_i view; link pins are seen as sampled levels. */
module sfs_sequencer_props
    import sfs_pkg::*;
#(
    parameter int unsigned LOCK_CYC  = LOCK_CYC_DEF,
    parameter int unsigned U_EXIT_LO = U_EXIT_LO_DEF,
    parameter int unsigned U_EXIT_HI = U_EXIT_HI_DEF,
    parameter int unsigned XFR_CYC   = XFR_CYC_DEF,
    parameter int unsigned COMP_CYC  = COMP_CYC_DEF,
    parameter int unsigned EP_CYC    = EP_CYC_DEF,
    parameter int unsigned OTP_CYC   = OTP_CYC_DEF
)
(
    input wire logic       ref_clk_i,
    input wire logic       rst_b_i,
    input wire logic       sck_i,
    input wire logic       cs_b_i,
    input wire logic       mosi_i,
    input wire logic       wp_b_i,
    input wire logic       high_supply_i,
    input wire logic       miso_o,
    input wire logic       miso_oe_o,
    input wire logic       ready_o,
    input wire logic       protect_o,
    input wire logic       ultra_sleep_o,
    input wire logic       deep_sleep_o,
    input wire logic       op_done_o,
    input wire logic [7:0] last_cmd_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sfs_cnt_t    busy_cnt;
    int unsigned lim;

    // cleared while asleep, so a wake is timed from its own exit only
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            busy_cnt <= '0;
        else if (ready_o || ultra_sleep_o || deep_sleep_o)
            busy_cnt <= '0;
        else
            busy_cnt <= busy_cnt + 1'b1;
    end

    always_comb
    begin
        case (last_cmd_o)
            OP_FREEZE_LOCK:   lim = LOCK_CYC;
            OP_PAGE_TO_BUF:   lim = XFR_CYC;
            OP_PAGE_COMPARE:  lim = COMP_CYC;
            OP_ERASE_PROGRAM: lim = EP_CYC;
            OP_OTP_PROGRAM:   lim = OTP_CYC;
            OP_ULTRA_SLEEP:   lim = high_supply_i ? U_EXIT_HI : U_EXIT_LO;
            OP_DEEP_RESUME:   lim = D_RESUME_CYC;
            default:          lim = 0;
        endcase
    end

    prot_on_a: assert property ($fell(wp_b_i) |-> ##[1:100] protect_o)
        else $error("protection late after wp low");
    prot_off_a: assert property ($rose(wp_b_i) |-> ##[1:100] !protect_o)
        else $error("protection late after wp high");
    busy_time_a: assert property (op_done_o |-> busy_cnt <= lim)
        else $error("timed operation overran");
    done_once_a: assert property (op_done_o |=> !op_done_o)
        else $error("done pulse too long");
    done_idle_a: assert property (op_done_o |-> ready_o && !ultra_sleep_o && !deep_sleep_o)
        else $error("done without idle");
    ultra_entry_a: assert property ($changed(last_cmd_o) && last_cmd_o == OP_ULTRA_SLEEP |-> ##[0:300] ultra_sleep_o)
        else $error("ultra sleep entry late");
    deep_entry_a: assert property ($changed(last_cmd_o) && last_cmd_o == OP_DEEP_SLEEP |-> ##[0:200] deep_sleep_o)
        else $error("deep sleep entry late");
    link_quiet_a: assert property (cs_b_i && $past(cs_b_i) |-> !miso_oe_o)
        else $error("output driven while deselected");

    c_done: cover property (op_done_o);
    c_ultra: cover property ($rose(ultra_sleep_o));
    c_deep: cover property ($rose(deep_sleep_o));
endmodule

bind sfs_sequencer sfs_sequencer_props #(
    .LOCK_CYC(LOCK_CYC), .U_EXIT_LO(U_EXIT_LO), .U_EXIT_HI(U_EXIT_HI), .XFR_CYC(XFR_CYC),
    .COMP_CYC(COMP_CYC), .EP_CYC(EP_CYC), .OTP_CYC(OTP_CYC)
) u_props (
    .ref_clk_i, .rst_b_i, .sck_i, .cs_b_i, .mosi_i, .wp_b_i, .high_supply_i, .miso_o,
    .miso_oe_o, .ready_o, .protect_o, .ultra_sleep_o, .deep_sleep_o, .op_done_o, .last_cmd_o
);

// ==== sfs_host_model.sv ====
/* sfs_host_model: host link controller that frames one command at a time.
   assumes the device drives miso on falling edges; clock stands between frames. */
module sfs_host_model
(
    output logic      sck_o,
    output logic      cs_b_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sck_o  = 1'b0;
        cs_b_o = 1'b1;
        mosi_o = 1'b0;
    end

    // hp is the half period; slow opcodes get a longer one
    task automatic frame(input logic [7:0] op, input int nrd, input logic m3, input realtime hp,
                         output logic [15:0] rx, output logic [15:0] rxe, output logic oe);
        rx  = '0;
        rxe = '0;
        oe  = 1'b1;
        sck_o = m3;
        #(hp);
        cs_b_o = 1'b0;
        mosi_o = op[7];
        for (int i = 7; i >= 0; i--)
        begin
            sck_o = 1'b0;
            #(hp);
            sck_o = 1'b1;
            #1;
            if (i > 0)
                mosi_o = op[i-1];
            #(hp - 1);
        end
        for (int k = 0; k <= nrd; k++)
        begin
            if (k > 0)
                rx = {rx[14:0], miso_i};
            sck_o = 1'b0;
            if (k < nrd)
            begin
                #(hp - 1);
                rxe = {rxe[14:0], miso_i};
                oe  = oe & miso_oe_i;
                #1;
                sck_o = 1'b1;
                #(hp);
            end
        end
        sck_o = m3;
        #(hp);
        cs_b_o = 1'b1;
        mosi_o = ~mosi_o; // released line must not look held
        #30;
    endtask
endmodule

// ==== tb.sv ====
/* tb: self-checking bench for sfs_sequencer driven by the host model.
   assumes shortened busy counts; the host model makes the link clock. */
module tb
    import sfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P_LOCK = 40, P_XFR = 44, P_COMP = 48, P_EP = 52, P_OTP = 56;
    localparam int P_ULO  = 60, P_UHI = 30, LIMIT = 20000;
    logic            ref_clk_i, rst_b_i, wp_b_i, high_supply_i, oe;
    logic [15:0]     rx, rxe;
    wire logic       sck, cs_b, mosi, miso, miso_oe, ready, protect, u_sleep, d_sleep, op_done;
    wire logic [7:0] last_cmd;
    wire logic [2:0] flags = {d_sleep, u_sleep, ready};
    int              cyc = 0, since_cs = 0, done_cnt = 0, bad_count = 0, samples_checked = 0;

    sfs_sequencer #(
        .LOCK_CYC(P_LOCK), .U_EXIT_LO(P_ULO), .U_EXIT_HI(P_UHI), .XFR_CYC(P_XFR),
        .COMP_CYC(P_COMP), .EP_CYC(P_EP), .OTP_CYC(P_OTP)
    ) DUT (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sck_i(sck), .cs_b_i(cs_b), .mosi_i(mosi),
        .wp_b_i(wp_b_i), .high_supply_i(high_supply_i), .miso_o(miso), .miso_oe_o(miso_oe),
        .ready_o(ready), .protect_o(protect), .ultra_sleep_o(u_sleep), .deep_sleep_o(d_sleep),
        .op_done_o(op_done), .last_cmd_o(last_cmd)
    );
    sfs_host_model host (.sck_o(sck), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        since_cs <= (cs_b === 1'b1) ? since_cs + 1 : 0;
        done_cnt <= done_cnt + int'(op_done === 1'b1);
        if (cyc == LIMIT)
        begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] op, input int nrd, input logic m3, input realtime hp);
        host.frame(op, nrd, m3, hp, rx, rxe, oe);
        @(negedge ref_clk_i);
    endtask

    // t0 is the cycle of select rise; lim bounds the wait in core cycles
    task automatic wait_hi(input int w, input int t0, input int lim);
        while (flags[w] !== 1'b1 && cyc - t0 < lim)
            @(negedge ref_clk_i);
        chk({15'h0, flags[w] === 1'b1 && cyc - t0 <= lim}, 16'h0001);
    endtask

    task automatic t_status();
        logic [7:0] b;
        for (int m = 0; m < 4; m++)
        begin
            wp_b_i = m[1];
            repeat (100) @(negedge ref_clk_i);
            chk({15'h0, protect}, {15'h0, ~m[1]});
            b = {1'b1, 5'h00, ~m[1], 1'b0};
            send(OP_STATUS_READ, 16, m[0], 7.5);
            chk(rx, {b, b});
            chk(rxe, {b, b});
            chk({15'h0, oe}, 16'h0001);
        end
    endtask

    task automatic t_timed();
        logic [7:0] ops [5] = '{OP_FREEZE_LOCK, OP_PAGE_TO_BUF, OP_PAGE_COMPARE, OP_ERASE_PROGRAM, OP_OTP_PROGRAM};
        int         lims [5] = '{P_LOCK, P_XFR, P_COMP, P_EP, P_OTP};
        logic [7:0] rd_ops [4] = '{8'h0B, 8'h03, 8'h01, 8'h1B};
        realtime    rd_hp [4] = '{7.5, 12.5, 35.0, 7.5};
        int         t0;
        int         d0;
        for (int i = 0; i < 5; i++)
        begin
            d0 = done_cnt;
            send(ops[i], 0, i[0], 7.5);
            t0 = cyc - since_cs;
            repeat (3) @(negedge ref_clk_i);
            chk({7'h00, ready, last_cmd}, {8'h00, ops[i]});
            send(ops[(i + 1) % 5], 0, 1'b0, 7.5);
            chk({7'h00, ready, last_cmd}, {8'h00, ops[i]});
            wait_hi(0, t0, lims[i]);
            repeat (2) @(negedge ref_clk_i);
            chk(16'(done_cnt - d0), 16'h0001);
        end
        for (int i = 0; i < 4; i++)
        begin
            send(rd_ops[i], 0, 1'b0, rd_hp[i]);
            repeat (20) @(negedge ref_clk_i);
            chk({7'h00, ready, last_cmd}, {8'h01, OP_OTP_PROGRAM});
        end
    endtask

    task automatic t_ultra(input logic hs);
        int t0;
        high_supply_i = hs;
        repeat (5) @(negedge ref_clk_i);
        send(OP_ULTRA_SLEEP, 0, hs, 7.5);
        t0 = cyc - since_cs;
        wait_hi(1, t0, U_ENTRY_CYC);
        chk({14'h0, u_sleep, ready}, 16'h0002);
        send(8'hFF, 0, 1'b0, 7.5);
        t0 = cyc - since_cs;
        wait_hi(0, t0, hs ? P_UHI : P_ULO);
        chk({15'h0, u_sleep}, 16'h0000);
    endtask

    task automatic t_deep();
        int t0;
        send(OP_DEEP_SLEEP, 0, 1'b0, 7.5);
        t0 = cyc - since_cs;
        wait_hi(2, t0, D_ENTRY_CYC);
        send(OP_FREEZE_LOCK, 0, 1'b1, 7.5);
        send(OP_STATUS_READ, 16, 1'b0, 7.5);
        chk({7'h00, oe, last_cmd}, {8'h00, OP_DEEP_SLEEP});
        chk(rx, 16'h0000);
        send(OP_DEEP_RESUME, 0, 1'b0, 7.5);
        t0 = cyc - since_cs;
        wait_hi(0, t0, D_RESUME_CYC);
        chk({6'h00, d_sleep, ready, last_cmd}, {8'h01, OP_DEEP_RESUME});
    endtask

    initial
    begin
        rst_b_i       = 1'b0;
        wp_b_i        = 1'b1;
        high_supply_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        chk({ready, protect, u_sleep, d_sleep, miso_oe, 3'h0, last_cmd}, 16'h8000);
        t_status();
        t_timed();
        t_ultra(1'b0);
        t_deep();
        t_ultra(1'b1);
        summarize();
    end
endmodule
